/* File: prl_map.vh */
// Register map, field positions and reset values of the pin routing block
`ifndef PRL_MAP_VH
`define PRL_MAP_VH

// ****************************************************
// Register indices, byte address is four times these
// ****************************************************
`define PRL_IDX_LAT_A 12'hF83
`define PRL_IDX_LAT_B 12'hF84
`define PRL_IDX_LAT_C 12'hF85
`define PRL_IDX_DIR_A 12'hF88
`define PRL_IDX_DIR_B 12'hF89
`define PRL_IDX_DIR_C 12'hF8A
`define PRL_IDX_DIR_E 12'hF8C
`define PRL_IDX_VAL_A 12'hF8D
`define PRL_IDX_VAL_B 12'hF8E
`define PRL_IDX_VAL_C 12'hF8F
`define PRL_IDX_VAL_E 12'hF91
`define PRL_IDX_OSEL 12'hE00
`define PRL_IDX_ISEL 12'hE40
`define PRL_IDX_LOCK 12'hE80

// ****************************************************
// Reset values
// ****************************************************
`define PRL_LAT_RST 8'h00
`define PRL_DIR_RST 8'hFF
`define PRL_DIR_E_RST 1'b1
`define PRL_OSEL_NONE 5'h1F

// ****************************************************
// Fields and codes
// ****************************************************
`define PRL_KEY_FIRST 8'h55
`define PRL_KEY_SECOND 8'hAA
`define PRL_BITOP_FLAG 8
`define PRL_BITOP_SET 9
`define PRL_BITOP_IDX_HI 12
`define PRL_BITOP_IDX_LO 10
`define PRL_DBG_BIT6 6
`define PRL_DBG_BIT7 7
`define PRL_E_IN_BIT 3
`define PRL_NUM_PINS 24
`define PRL_RESP_OKAY 2'b00
`define PRL_RESP_SLVERR 2'b10

`endif

/* File: prl_sync.v */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none

module prl_sync #(
  parameter W = 25
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Levels
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

/* File: prl_lock_ctl.v */
// Routing lock bit with unlock sequence and one-way option
`timescale 1ns/10ps
`default_nettype none
`include "prl_map.vh"

module prl_lock_ctl (
  // Clock and resets
  input wire aclk,
  input wire aresetn,
  input wire sys_rst_n,
  // Write events from the register slave
  input wire wr_fire,
  input wire lock_hit,
  input wire key_valid,
  input wire [7:0] key,
  input wire bitop,
  input wire bitop_set,
  input wire [2:0] bitop_idx,
  // Configuration and state
  input wire routing_one_way_cfg,
  output wire routing_locked_bit,
  output wire [3:0] lock_status
);

  localparam ST_IDLE = 3'b001;
  localparam ST_KEY1 = 3'b010;
  localparam ST_ARMED = 3'b100;

  reg [2:0] st_q;
  reg locked_q;
  reg clr_used_q;
  reg set_used_q;
  wire key1 = lock_hit & key_valid & ~bitop & (key == `PRL_KEY_FIRST);
  wire key2 = lock_hit & key_valid & ~bitop & (key == `PRL_KEY_SECOND);
  wire op_ok = lock_hit & bitop & (bitop_idx == 3'd0);
  wire may_clr = ~routing_one_way_cfg | ~clr_used_q;
  wire may_set = ~routing_one_way_cfg | ~set_used_q;

  // Any other write breaks the sequence, so the steps must be back to back
  always @(posedge aclk)
  begin
    if (!aresetn || !sys_rst_n)
    begin
      st_q <= ST_IDLE;
      locked_q <= 1'b0;
      clr_used_q <= 1'b0;
      set_used_q <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (st_q)
        ST_KEY1:
          st_q <= key2 ? ST_ARMED : (key1 ? ST_KEY1 : ST_IDLE);
        ST_ARMED:
        begin
          st_q <= key1 ? ST_KEY1 : ST_IDLE;
          if (op_ok && bitop_set && may_set)
          begin
            locked_q <= 1'b1;
            set_used_q <= 1'b1;
          end
          else if (op_ok && !bitop_set && may_clr)
          begin
            locked_q <= 1'b0;
            clr_used_q <= 1'b1;
          end
        end
        default:
          st_q <= key1 ? ST_KEY1 : ST_IDLE;
      endcase
    end
  end

  assign routing_locked_bit = locked_q;
  assign lock_status = {st_q == ST_ARMED, set_used_q, clr_used_q, locked_q};

endmodule
`default_nettype wire

/* File: prl_pin_routing.v */
// Pin routing with lock, port latches, directions and pin values
`timescale 1ns/10ps
`default_nettype none
`include "prl_map.vh"

module prl_pin_routing #(
  parameter N_OUT = 4,
  parameter N_IN = 4
) (
  // Clock and resets
  input wire aclk,
  input wire aresetn,
  input wire sys_rst_n,
  // AXI4-Lite write address
  input wire awvalid,
  output wire awready,
  input wire [13:0] awaddr,
  // AXI4-Lite write data
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output wire arready,
  input wire [13:0] araddr,
  // AXI4-Lite read data
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  // Device state
  input wire debug_active,
  input wire ext_reset_pin_enable,
  input wire routing_one_way_cfg,
  // Device pins
  input wire [23:0] pin_i,
  input wire pin_e3_i,
  output wire [23:0] pin_o,
  output wire [23:0] pin_oe,
  // Peripheral side
  input wire [N_OUT-1:0] periph_out_i,
  output wire [N_IN-1:0] periph_in_o
);

  // ****************************************************
  // Helper functions
  // ****************************************************
  // Index of the k-th register in a routing bank
  function [11:0] idx_add;
    input [11:0] base;
    input integer k;
    begin
      idx_add = base + k[11:0];
    end
  endfunction

  // True for every index that answers with OKAY
  function is_mapped;
    input [11:0] idx;
    begin
      case (idx)
        `PRL_IDX_LAT_A, `PRL_IDX_LAT_B, `PRL_IDX_LAT_C,
        `PRL_IDX_DIR_A, `PRL_IDX_DIR_B, `PRL_IDX_DIR_C, `PRL_IDX_DIR_E,
        `PRL_IDX_VAL_A, `PRL_IDX_VAL_B, `PRL_IDX_VAL_C, `PRL_IDX_VAL_E,
        `PRL_IDX_LOCK:
          is_mapped = 1'b1;
        default:
          is_mapped = ((idx >= `PRL_IDX_OSEL) &&
                       (idx < idx_add(`PRL_IDX_OSEL, N_OUT))) ||
                      ((idx >= `PRL_IDX_ISEL) &&
                       (idx < idx_add(`PRL_IDX_ISEL, N_IN)));
      endcase
    end
  endfunction

  // ****************************************************
  // Write channel capture
  // ****************************************************
  reg aw_have_q, w_have_q, bvalid_q;
  reg [11:0] wr_idx_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [1:0] bresp_q;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire lane0 = w_strb_q[0];

  assign awready = ~aw_have_q;
  assign wready = ~w_have_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Address and data may arrive in either order; both are held until done
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wr_idx_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PRL_RESP_OKAY;
    end
    else
    begin
      if (awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        wr_idx_q <= awaddr[13:2];
      end
      if (wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(wr_idx_q) ? `PRL_RESP_OKAY : `PRL_RESP_SLVERR;
      end
      else if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Port latches and directions
  // ****************************************************
  reg [7:0] lat_a_q, lat_b_q, lat_c_q;
  reg [7:0] dir_a_q, dir_b_q, dir_c_q;
  reg dir_e_q;

  // Any reset clears the latches and sets every direction bit; port E value is read-only, writes dropped
  always @(posedge aclk)
  begin
    if (!aresetn || !sys_rst_n)
    begin
      lat_a_q <= `PRL_LAT_RST;
      lat_b_q <= `PRL_LAT_RST;
      lat_c_q <= `PRL_LAT_RST;
      dir_a_q <= `PRL_DIR_RST;
      dir_b_q <= `PRL_DIR_RST;
      dir_c_q <= `PRL_DIR_RST;
      dir_e_q <= `PRL_DIR_E_RST;
    end
    else if (wr_fire && lane0)
    begin
      case (wr_idx_q)
        `PRL_IDX_LAT_A, `PRL_IDX_VAL_A: lat_a_q <= w_data_q[7:0];
        `PRL_IDX_LAT_B, `PRL_IDX_VAL_B: lat_b_q <= w_data_q[7:0];
        `PRL_IDX_LAT_C, `PRL_IDX_VAL_C: lat_c_q <= w_data_q[7:0];
        `PRL_IDX_DIR_A: dir_a_q <= w_data_q[7:0];
        `PRL_IDX_DIR_B: dir_b_q <= w_data_q[7:0];
        `PRL_IDX_DIR_C: dir_c_q <= w_data_q[7:0];
        `PRL_IDX_DIR_E: dir_e_q <= w_data_q[0];
        default: dir_e_q <= dir_e_q;
      endcase
    end
  end

  // ****************************************************
  // Routing lock
  // ****************************************************
  wire routing_locked_bit;
  wire [3:0] lock_status;

  prl_lock_ctl i_prl_lock_ctl (
    .aclk(aclk), .aresetn(aresetn), .sys_rst_n(sys_rst_n),
    .wr_fire(wr_fire), .lock_hit(wr_idx_q == `PRL_IDX_LOCK),
    .key_valid(lane0), .key(w_data_q[7:0]),
    .bitop(w_data_q[`PRL_BITOP_FLAG] & w_strb_q[1]),
    .bitop_set(w_data_q[`PRL_BITOP_SET]),
    .bitop_idx(w_data_q[`PRL_BITOP_IDX_HI:`PRL_BITOP_IDX_LO]),
    .routing_one_way_cfg(routing_one_way_cfg),
    .routing_locked_bit(routing_locked_bit), .lock_status(lock_status)
  );

  // ****************************************************
  // Routing selections
  // ****************************************************
  reg [4:0] osel_q [0:N_OUT-1];
  reg [4:0] isel_q [0:N_IN-1];
  integer k;

  // Power-on reset and unlocked writes only; no sleep input
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (k = 0; k < N_OUT; k = k + 1)
        osel_q[k] <= `PRL_OSEL_NONE;
      for (k = 0; k < N_IN; k = k + 1)
        isel_q[k] <= k[4:0];
    end
    else if (wr_fire && lane0 && !routing_locked_bit)
    begin
      for (k = 0; k < N_OUT; k = k + 1)
        if (wr_idx_q == idx_add(`PRL_IDX_OSEL, k))
          osel_q[k] <= w_data_q[4:0];
      for (k = 0; k < N_IN; k = k + 1)
        if (wr_idx_q == idx_add(`PRL_IDX_ISEL, k))
          isel_q[k] <= w_data_q[4:0];
    end
  end

  // ****************************************************
  // Pin synchronisation and port values
  // ****************************************************
  wire [24:0] pin_s;
  wire [7:0] val_b, val_e;

  prl_sync #(.W(25)) i_prl_sync (
    .aclk(aclk), .aresetn(aresetn),
    .async_i({pin_e3_i, pin_i}), .sync_o(pin_s)
  );

  // Debug owns port B bits 6 and 7, so they read high
  assign val_b = pin_s[15:8] |
                 ({8{debug_active}} & ((8'h01 << `PRL_DBG_BIT6) |
                                       (8'h01 << `PRL_DBG_BIT7)));
  // Reset pin function forces the input-only bit high
  assign val_e = {4'h0, pin_s[24] | ext_reset_pin_enable, 3'h0};

  // ****************************************************
  // Read channel
  // ****************************************************
  reg rvalid_q;
  reg [31:0] rdata_q, rd_word;
  reg [1:0] rresp_q;
  wire [11:0] rd_idx = araddr[13:2];
  integer rk; // Own index per process; a shared one retriggers loops

  // Value registers return live pins, never the latch
  always @*
  begin
    rd_word = 32'h00000000;
    case (rd_idx)
      `PRL_IDX_LAT_A: rd_word[7:0] = lat_a_q;
      `PRL_IDX_LAT_B: rd_word[7:0] = lat_b_q;
      `PRL_IDX_LAT_C: rd_word[7:0] = lat_c_q;
      `PRL_IDX_DIR_A: rd_word[7:0] = dir_a_q;
      `PRL_IDX_DIR_B: rd_word[7:0] = dir_b_q;
      `PRL_IDX_DIR_C: rd_word[7:0] = dir_c_q;
      `PRL_IDX_DIR_E: rd_word[0] = dir_e_q;
      `PRL_IDX_VAL_A: rd_word[7:0] = pin_s[7:0];
      `PRL_IDX_VAL_B: rd_word[7:0] = val_b;
      `PRL_IDX_VAL_C: rd_word[7:0] = pin_s[23:16];
      `PRL_IDX_VAL_E: rd_word[7:0] = val_e;
      `PRL_IDX_LOCK: rd_word[4:0] = {lock_status, routing_one_way_cfg};
      default:
      begin
        for (rk = 0; rk < N_OUT; rk = rk + 1)
          if (rd_idx == idx_add(`PRL_IDX_OSEL, rk))
            rd_word[4:0] = osel_q[rk];
        for (rk = 0; rk < N_IN; rk = rk + 1)
          if (rd_idx == idx_add(`PRL_IDX_ISEL, rk))
            rd_word[4:0] = isel_q[rk];
      end
    endcase
  end

  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // One read at a time; data held until the master takes it
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PRL_RESP_OKAY;
    end
    else if (arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= is_mapped(rd_idx) ? `PRL_RESP_OKAY : `PRL_RESP_SLVERR;
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
  end

  // ****************************************************
  // Pin and peripheral routing
  // ****************************************************
  reg [23:0] drv_d, pin_o_q, pin_oe_q;
  reg [N_IN-1:0] pin_in_q;
  integer p, dk, ik;

  // Routed peripheral output beats the latch; highest k wins a shared pin
  always @*
  begin
    drv_d = {lat_c_q, lat_b_q, lat_a_q};
    for (p = 0; p < `PRL_NUM_PINS; p = p + 1)
      for (dk = 0; dk < N_OUT; dk = dk + 1)
        if (osel_q[dk] == p[4:0])
          drv_d[p] = periph_out_i[dk];
  end

  // Registered outputs; a clear direction bit drives the pin
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o_q <= 24'h000000;
      pin_oe_q <= 24'h000000;
      pin_in_q <= {N_IN{1'b0}};
    end
    else
    begin
      pin_o_q <= drv_d;
      pin_oe_q <= ~{dir_c_q, dir_b_q, dir_a_q};
      for (ik = 0; ik < N_IN; ik = ik + 1)
        pin_in_q[ik] <= (isel_q[ik] < `PRL_NUM_PINS) ?
                        pin_s[isel_q[ik]] : 1'b0;
    end
  end

  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign periph_in_o = pin_in_q;

endmodule
`default_nettype wire

/* File: prl_props.sv */
// Concurrent checks on the ports of the pin routing block
`timescale 1ns/10ps
`default_nettype none
`include "prl_map.vh"

module prl_props (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sys_rst_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [13:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [13:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Device state and pads
  input wire logic debug_active,
  input wire logic ext_reset_pin_enable,
  input wire logic [23:0] pin_o,
  input wire logic [23:0] pin_oe
);
  // Either reset clears latches, so both mute the checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !sys_rst_n);
  // Whole write or read taken at one edge
  sequence s_wr(logic [11:0] idx);
    awvalid && awready && wvalid && wready && wstrb[0] && awaddr == {idx, 2'b00};
  endsequence
  sequence s_rd(logic [11:0] idx);
    arvalid && arready && araddr == {idx, 2'b00};
  endsequence
  // Register lands one edge after taking, the pad flop one edge later
  property p_latch_pin;
    s_wr(`PRL_IDX_VAL_A) |=> ##2 pin_o[7:0] == $past(wdata[7:0], 3);
  endproperty
  property p_dir_oe;
    s_wr(`PRL_IDX_DIR_A) |=> ##2 pin_oe[7:0] == ~$past(wdata[7:0], 3);
  endproperty
  property p_dbg_bits;
    s_rd(`PRL_IDX_VAL_B) ##0 debug_active |=> rdata[7:6] == 2'b11;
  endproperty
  property p_e3_high;
    s_rd(`PRL_IDX_VAL_E) ##0 ext_reset_pin_enable |=> rdata[3];
  endproperty
  property p_resp_due;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  property p_w_block;
    bvalid |-> !awready && !wready;
  endproperty
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  property p_b_once;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_r_once;
    rvalid && rready |=> !rvalid;
  endproperty
  a_latch_pin: assert property (p_latch_pin)
    else $error("pad level not from value write");
  a_dir_oe: assert property (p_dir_oe)
    else $error("pad enable not from direction");
  a_dbg_bits: assert property (p_dbg_bits)
    else $error("debug bits not high");
  a_e3_high: assert property (p_e3_high)
    else $error("input only bit not high");
  a_resp_due: assert property (p_resp_due)
    else $error("write response late");
  a_w_block: assert property (p_w_block)
    else $error("write taken while answering");
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answering");
  a_b_once: assert property (p_b_once)
    else $error("write answer repeated");
  a_r_once: assert property (p_r_once)
    else $error("read answer repeated");
endmodule

bind prl_pin_routing prl_props i_prl_props (.aclk, .aresetn, .sys_rst_n,
  .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
  .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
  .debug_active, .ext_reset_pin_enable, .pin_o, .pin_oe);
`default_nettype wire

/* File: prl_pin_model.sv */
// Pad model: a pad shows the block where driven, the board elsewhere
`timescale 1ns/10ps
`default_nettype none

module prl_pin_model (
  // Block side
  input wire logic [23:0] pin_o,
  input wire logic [23:0] pin_oe,
  // Board side level on undriven pads
  input wire logic [23:0] ext_lvl,
  // Pad levels
  output logic [23:0] pin_i
);
  // Board source yields wherever the block drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

/* File: prl_pin_routing_tb.sv */
// Self-checking bench of the pin routing block
`timescale 1ns/10ps
`default_nettype none
`include "prl_map.vh"

module prl_pin_routing_tb;
  logic aclk, aresetn, sys_rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic debug_active, ext_reset_pin_enable, routing_one_way_cfg, pin_e3_i;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rd_data;
  logic [3:0] wstrb, periph_out_i;
  logic [23:0] ext_lvl, pin_i;
  logic [1:0] rsp;
  logic [45:0] rows [0:7];
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [23:0] pin_o, pin_oe;
  wire [3:0] periph_in_o;
  integer errors, checked, i;

  prl_pin_routing i_prl_pin_routing (.aclk, .aresetn, .sys_rst_n, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .debug_active, .ext_reset_pin_enable, .routing_one_way_cfg, .pin_i,
    .pin_e3_i, .pin_o, .pin_oe, .periph_out_i, .periph_in_o);
  prl_pin_model i_prl_pin_model (.pin_o, .pin_oe, .ext_lvl, .pin_i);

  // 25 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is looked at mid-cycle so the release edge is the taking edge
  task automatic wr(input logic [11:0] idx, input logic [31:0] d,
    input logic [3:0] s);
    logic a, w, ta, tw;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    while (!a || !w)
    begin
      @(negedge aclk);
      ta = awready && !a;
      tw = wready && !w;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      a = a | ta;
      w = w | tw;
    end
    do @(negedge aclk); while (!bvalid);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd_data = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Key pair then the bit operation, no other write between
  task automatic lk(input logic [31:0] op);
    wr(`PRL_IDX_LOCK, 32'h55, 4'h1);
    wr(`PRL_IDX_LOCK, 32'hAA, 4'h1);
    wr(`PRL_IDX_LOCK, op, 4'h2);
    rd(`PRL_IDX_LOCK);
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors = errors + 1;
    results;
  end

  initial
  begin
    {errors, checked} = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, debug_active} = 0;
    {ext_reset_pin_enable, routing_one_way_cfg, pin_e3_i} = 0;
    {awaddr, araddr, wdata, wstrb, periph_out_i, ext_lvl} = 0;
    sys_rst_n = 1'b1;
    rows[0] = {`PRL_IDX_DIR_A, 32'hFF, `PRL_RESP_OKAY};
    rows[1] = {`PRL_IDX_DIR_B, 32'hFF, `PRL_RESP_OKAY};
    rows[2] = {`PRL_IDX_DIR_C, 32'hFF, `PRL_RESP_OKAY};
    rows[3] = {`PRL_IDX_DIR_E, 32'h01, `PRL_RESP_OKAY};
    rows[4] = {`PRL_IDX_LAT_A, 32'h00, `PRL_RESP_OKAY};
    rows[5] = {`PRL_IDX_LAT_B, 32'h00, `PRL_RESP_OKAY};
    rows[6] = {`PRL_IDX_OSEL, 32'h1F, `PRL_RESP_OKAY};
    rows[7] = {12'h100, 32'h00, `PRL_RESP_SLVERR};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      rd(rows[i][45:34]);
      chk("reset read", rd_data, rows[i][33:2]);
      chk("reset resp", {30'h0, rsp}, {30'h0, rows[i][1:0]});
    end
    $display("Test reset values done");
    wr(`PRL_IDX_VAL_A, 32'h5A, 4'h1);
    rd(`PRL_IDX_LAT_A);
    chk("latch a", rd_data, 32'h5A);
    ext_lvl <= 24'h0000C3;
    repeat (3) @(posedge aclk);
    rd(`PRL_IDX_VAL_A);
    chk("value a in", rd_data, 32'hC3);
    wr(`PRL_IDX_DIR_A, 32'h00, 4'h1);
    repeat (3) @(posedge aclk);
    chk("oe a", pin_oe, 32'hFF);
    rd(`PRL_IDX_VAL_A);
    chk("value a out", rd_data, 32'h5A);
    debug_active <= 1'b1;
    ext_reset_pin_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`PRL_IDX_VAL_B);
    chk("value b debug", rd_data, 32'hC0);
    rd(`PRL_IDX_VAL_E);
    chk("value e enabled", rd_data, 32'h08);
    debug_active <= 1'b0;
    ext_reset_pin_enable <= 1'b0;
    wr(`PRL_IDX_VAL_E, 32'hFF, 4'h1);
    chk("value e resp", {30'h0, rsp}, {30'h0, `PRL_RESP_OKAY});
    wr(12'h100, 32'hFF, 4'h1);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, `PRL_RESP_SLVERR});
    repeat (3) @(posedge aclk);
    rd(`PRL_IDX_VAL_B);
    chk("value b", rd_data, 32'h00);
    rd(`PRL_IDX_VAL_E);
    chk("value e", rd_data, 32'h00);
    pin_e3_i <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`PRL_IDX_VAL_E);
    chk("value e pin", rd_data, 32'h08);
    $display("Test port values done");
    // Peripheral 0 out and in share pad A5, as a two-way signal must
    wr(`PRL_IDX_OSEL, 32'h05, 4'h1);
    wr(`PRL_IDX_ISEL, 32'h05, 4'h1);
    periph_out_i <= 4'h1;
    repeat (4) @(posedge aclk);
    @(negedge aclk); // Input flop updates on the fourth edge itself
    chk("pad a5", pin_o[5], 32'h1);
    chk("periph in", periph_in_o[0], 32'h1);
    lk(32'h300);
    chk("locked", rd_data[1], 32'h1);
    wr(`PRL_IDX_OSEL, 32'h06, 4'h1);
    rd(`PRL_IDX_OSEL);
    chk("osel frozen", rd_data, 32'h05);
    // Bare op, aborted keys, wrong bit, plain byte: lock must hold
    wr(`PRL_IDX_LOCK, 32'h100, 4'h2);
    wr(`PRL_IDX_LOCK, 32'h55, 4'h1);
    wr(`PRL_IDX_LOCK, 32'hAA, 4'h1);
    wr(`PRL_IDX_LAT_B, 32'h00, 4'h1);
    wr(`PRL_IDX_LOCK, 32'h100, 4'h2);
    lk(32'h500);
    lk(32'h000);
    chk("still locked", rd_data[1], 32'h1);
    lk(32'h100);
    chk("unlocked", rd_data[1], 32'h0);
    wr(`PRL_IDX_OSEL, 32'h06, 4'h1);
    rd(`PRL_IDX_OSEL);
    chk("osel free", rd_data, 32'h06);
    $display("Test lock done");
    routing_one_way_cfg <= 1'b1;
    sys_rst_n <= 1'b0;
    repeat (2) @(posedge aclk);
    sys_rst_n <= 1'b1;
    rd(`PRL_IDX_OSEL);
    chk("osel kept", rd_data, 32'h06);
    lk(32'h300);
    chk("one way set", rd_data[1], 32'h1);
    lk(32'h100);
    chk("one way clear", rd_data[1], 32'h0);
    lk(32'h300);
    chk("second set", rd_data[1], 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PRL_IDX_OSEL);
    chk("osel default", rd_data, 32'h1F);
    rd(`PRL_IDX_ISEL);
    chk("isel default", rd_data, 32'h00);
    lk(32'h100);
    lk(32'h300);
    chk("one way lifted", rd_data[1], 32'h1);
    lk(32'h100);
    chk("relock holds", rd_data[1], 32'h1);
    $display("Test resets done");
    results;
  end
endmodule
`default_nettype wire
